// >>> design/lscr_params.svh
// register map, field positions, reset values and timing for the light sensor register bank
`ifndef LSCR_PARAMS_SVH
`define LSCR_PARAMS_SVH

// byte addresses on the register port
`define LSCR_ADDR_WAIT_CFG   8'h8d
`define LSCR_ADDR_GAIN_CFG   8'h90
`define LSCR_ADDR_REVISION   8'h91
`define LSCR_ADDR_DEV_TYPE   8'h92
`define LSCR_ADDR_STATUS     8'h93
`define LSCR_ADDR_VIS_LO     8'h94
`define LSCR_ADDR_VIS_HI     8'h95
`define LSCR_ADDR_IR_LO      8'h96
`define LSCR_ADDR_IR_HI      8'h97
`define LSCR_ADDR_PKG_CODE   8'h9e
`define LSCR_ADDR_MISC_CFG   8'hab

// field positions
`define LSCR_BIT_WAIT_STRETCH 2
`define LSCR_BIT_SAT_FLAG     7
`define LSCR_BIT_THR_FLAG     4
`define LSCR_BIT_CAL_FLAG     3
`define LSCR_BIT_READ_CLEAR   7

// reset values and fixed reserved fields
`define LSCR_RST_WAIT_CFG    8'h80
`define LSCR_RST_GAIN_CFG    8'h00
`define LSCR_RST_MISC_CFG    8'h4c
`define LSCR_RST_RESULT      16'h0000
`define LSCR_REV_RESERVED    5'h0c

// timing: one wait step, the clock period, and the long-wait factor
`define LSCR_WAIT_STEP_NS       2800000
`define LSCR_CLK_PERIOD_NS      20
`define LSCR_WAIT_STRETCH_FACTOR 12

`endif

// >>> design/lscr_pkg.sv
// types shared by the light sensor register bank and its wait timer
package lscr_pkg;

	typedef logic [7:0] lscr_byte_t;

	// analog gain codes
	typedef enum logic [1:0] {
		LSCR_GAIN_1X  = 2'b00,
		LSCR_GAIN_4X  = 2'b01,
		LSCR_GAIN_16X = 2'b10,
		LSCR_GAIN_64X = 2'b11
	} lscr_gain_t;

	// wait timer states
	typedef enum logic {
		LSCR_WAIT_IDLE = 1'b0,
		LSCR_WAIT_RUN  = 1'b1
	} lscr_wait_state_t;

endpackage : lscr_pkg

// >>> design/lscr_wait_if.sv
// link between the register bank and the wait timer
`timescale 1ns/1ps
interface lscr_wait_if;
	logic               start;   // one-cycle launch pulse
	lscr_pkg::lscr_byte_t period; // programmed step count minus one
	logic               stretch; // long-wait select
	logic               done;    // one-cycle end pulse

	modport ctrl  (output start, output period, output stretch, input done);
	modport timer (input start, input period, input stretch, output done);
endinterface : lscr_wait_if

// >>> design/lscr_wait_timer.sv
// wait period down counter with optional long-wait stretch
`timescale 1ns/1ps
`include "lscr_params.svh"
module lscr_wait_timer #(
	parameter int unsigned STEP_CYCLES = (`LSCR_WAIT_STEP_NS + `LSCR_CLK_PERIOD_NS - 1)
	                                     / `LSCR_CLK_PERIOD_NS,
	parameter int unsigned STRETCH     = `LSCR_WAIT_STRETCH_FACTOR
) (
	input  wire logic   clk,     // system clock
	input  wire logic   sys_rst, // synchronous reset, high
	lscr_wait_if.timer  wt       // launch and completion
);
	import lscr_pkg::*;

	localparam int unsigned PRE_W = $clog2(STEP_CYCLES * STRETCH + 1);
	localparam logic [PRE_W-1:0] LEN_N = PRE_W'(STEP_CYCLES - 1);
	localparam logic [PRE_W-1:0] LEN_S = PRE_W'(STEP_CYCLES * STRETCH - 1);

	lscr_wait_state_t state_ff;
	logic [PRE_W-1:0] pre_ff;     // cycles left in the current step
	logic [7:0]       steps_ff;   // whole steps left after this one
	logic             stretch_ff; // stretch latched at launch
	logic             done_ff;
	logic             launch;
	logic             last;

	assign launch  = (state_ff == LSCR_WAIT_IDLE) && wt.start;
	assign last    = (state_ff == LSCR_WAIT_RUN) && (pre_ff == '0) && (steps_ff == 8'h00);
	assign wt.done = done_ff;

	// a start while running is ignored so one period is never cut short
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= LSCR_WAIT_IDLE;
		end else begin
			unique case (state_ff)
				LSCR_WAIT_IDLE: if (launch) state_ff <= LSCR_WAIT_RUN;
				LSCR_WAIT_RUN:  if (last) state_ff <= LSCR_WAIT_IDLE;
			endcase
		end
	end

	// down counter of (value + 1) steps, each step long or short
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre_ff     <= '0;
			steps_ff   <= 8'h00;
			stretch_ff <= 1'b0;
		end else if (launch) begin
			steps_ff   <= wt.period;
			stretch_ff <= wt.stretch;
			pre_ff     <= wt.stretch ? LEN_S : LEN_N;
		end else if (state_ff == LSCR_WAIT_RUN) begin
			if (pre_ff == '0) begin
				pre_ff   <= stretch_ff ? LEN_S : LEN_N;
				steps_ff <= steps_ff - 8'h01;
			end else begin
				pre_ff <= pre_ff - PRE_W'(1);
			end
		end
	end

	// completion pulse, one cycle after the last counted cycle
	always_ff @(posedge clk) begin
		if (sys_rst) done_ff <= 1'b0;
		else done_ff <= last;
	end

	// helper counters for checking the period length
	logic [31:0] elapsed_ff;
	logic [7:0]  period_ff;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			elapsed_ff <= 32'h0000_0000;
			period_ff  <= 8'h00;
		end else if (launch) begin
			elapsed_ff <= 32'h0000_0000;
			period_ff  <= wt.period;
		end else if (state_ff == LSCR_WAIT_RUN) begin
			elapsed_ff <= elapsed_ff + 32'h0000_0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_launch;
		(state_ff == LSCR_WAIT_IDLE) && wt.start;
	endsequence

	a_wait_launch: assert property (s_launch |=> (state_ff == LSCR_WAIT_RUN)
		&& (steps_ff == $past(wt.period)) && (stretch_ff == $past(wt.stretch)))
		else $error("wait timer did not load on start");

	a_wait_plain: assert property (done_ff && !stretch_ff |->
		elapsed_ff == (32'(period_ff) + 32'h0000_0001) * STEP_CYCLES)
		else $error("short wait period has wrong length");

	a_wait_stretch: assert property (done_ff && stretch_ff |->
		elapsed_ff == (32'(period_ff) + 32'h0000_0001) * STEP_CYCLES * STRETCH)
		else $error("long wait period is not twelve times the short one");

endmodule : lscr_wait_timer

// >>> design/lscr_regs.sv
// configuration, identification, status and result registers of the light sensor
`timescale 1ns/1ps
`include "lscr_params.svh"
module lscr_regs #(
	parameter logic [2:0] SILICON_REVISION = 3'h5,  // arbitrary value
	parameter logic [5:0] DEVICE_TYPE      = 6'h2a, // arbitrary value
	parameter logic [3:0] PACKAGE_CODE     = 4'h7,  // arbitrary value
	parameter int unsigned WAIT_STEP_CYCLES = (`LSCR_WAIT_STEP_NS + `LSCR_CLK_PERIOD_NS - 1)
	                                          / `LSCR_CLK_PERIOD_NS
) (
	input  wire logic                 clk,                   // system clock
	input  wire logic                 sys_rst,               // synchronous reset, high
	input  wire logic [7:0]           reg_addr,              // register byte address
	input  wire logic                 reg_wr,                // write strobe
	input  wire logic                 reg_rd,                // read strobe
	input  wire lscr_pkg::lscr_byte_t reg_wdata,             // write data
	output lscr_pkg::lscr_byte_t      reg_rdata,             // read data
	output logic                      reg_rvalid,            // read data valid pulse
	input  wire logic                 sat_event,             // front-end saturated
	input  wire logic                 cal_done,              // calibration finished
	input  wire logic                 result_valid,          // new results present
	input  wire logic [15:0]          vis_result,            // visible channel result
	input  wire logic [15:0]          ir_result,             // infrared channel result
	input  wire logic                 thr_outside,           // visible result out of window
	input  wire logic [7:0]           persist_count_needed,  // out-of-window results needed
	input  wire logic                 wait_start,            // begin a wait period
	input  wire logic [7:0]           wait_period_value,     // wait steps minus one
	output logic                      wait_done,             // wait period over pulse
	output logic                      wait_stretch_enable,   // long-wait select
	output lscr_pkg::lscr_gain_t      gain_select,           // analog gain code
	output logic [6:0]                gain_mult              // analog gain factor
);
	import lscr_pkg::*;

	lscr_byte_t  wait_cfg_ff;
	lscr_byte_t  gain_cfg_ff;
	lscr_byte_t  misc_cfg_ff;
	lscr_byte_t  flag_status_ff;
	lscr_byte_t  nxt_flag_status;
	logic [15:0] vis_res_ff;
	logic [15:0] ir_res_ff;
	logic [7:0]  pers_cnt_ff;
	logic [7:0]  nxt_pers_cnt;
	lscr_byte_t  rdata_ff;
	lscr_byte_t  nxt_rdata;
	logic        rvalid_ff;
	logic [6:0]  gain_mult_ff;
	logic        thr_set;
	logic        status_rd;
	logic        status_wr;
	logic        read_clear;
	lscr_byte_t  set_vec;
	lscr_byte_t  clr_vec;

	lscr_wait_if wt_if();

	assign reg_rdata           = rdata_ff;
	assign reg_rvalid          = rvalid_ff;
	assign gain_mult           = gain_mult_ff;
	assign wait_stretch_enable = wait_cfg_ff[`LSCR_BIT_WAIT_STRETCH];
	assign gain_select         = lscr_gain_t'(gain_cfg_ff[1:0]);
	assign wait_done           = wt_if.done;

	// wait timer launch; the stretch bit travels with the start
	assign wt_if.start   = wait_start;
	assign wt_if.period  = wait_period_value;
	assign wt_if.stretch = wait_cfg_ff[`LSCR_BIT_WAIT_STRETCH];

	lscr_wait_timer #(
		.STEP_CYCLES (WAIT_STEP_CYCLES),
		.STRETCH     (`LSCR_WAIT_STRETCH_FACTOR)
	) u_wait_timer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wt      (wt_if.timer)
	);

	// writable configuration; reserved bits are stored as written
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_cfg_ff <= `LSCR_RST_WAIT_CFG;
			gain_cfg_ff <= `LSCR_RST_GAIN_CFG;
			misc_cfg_ff <= `LSCR_RST_MISC_CFG;
		end else if (reg_wr) begin
			if (reg_addr == `LSCR_ADDR_WAIT_CFG) wait_cfg_ff <= reg_wdata;
			if (reg_addr == `LSCR_ADDR_GAIN_CFG) gain_cfg_ff <= reg_wdata;
			if (reg_addr == `LSCR_ADDR_MISC_CFG) misc_cfg_ff <= reg_wdata;
		end
	end

	// gain factor, registered so the output comes straight from a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gain_mult_ff <= 7'h01;
		end else begin
			unique case (lscr_gain_t'(gain_cfg_ff[1:0]))
				LSCR_GAIN_1X:  gain_mult_ff <= 7'h01;
				LSCR_GAIN_4X:  gain_mult_ff <= 7'h04;
				LSCR_GAIN_16X: gain_mult_ff <= 7'h10;
				LSCR_GAIN_64X: gain_mult_ff <= 7'h40;
			endcase
		end
	end

	// results are latched only from the measurement side, never by writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vis_res_ff <= `LSCR_RST_RESULT;
			ir_res_ff  <= `LSCR_RST_RESULT;
		end else if (result_valid) begin
			vis_res_ff <= vis_result;
			ir_res_ff  <= ir_result;
		end
	end

	// persistence counter; saturates so a long run keeps raising the flag
	always_comb begin
		nxt_pers_cnt = (pers_cnt_ff == 8'hff) ? pers_cnt_ff : pers_cnt_ff + 8'h01;
		thr_set      = result_valid && thr_outside &&
		               ((persist_count_needed == 8'h00) || (nxt_pers_cnt >= persist_count_needed));
	end

	always_ff @(posedge clk) begin
		if (sys_rst) pers_cnt_ff <= 8'h00;
		else if (result_valid) pers_cnt_ff <= thr_outside ? nxt_pers_cnt : 8'h00;
	end

	// flag set and clear terms; a set in the clearing cycle wins
	always_comb begin
		status_rd  = reg_rd && (reg_addr == `LSCR_ADDR_STATUS);
		status_wr  = reg_wr && (reg_addr == `LSCR_ADDR_STATUS);
		read_clear = status_rd && misc_cfg_ff[`LSCR_BIT_READ_CLEAR];
		set_vec    = 8'h00;
		set_vec[`LSCR_BIT_SAT_FLAG] = sat_event;
		set_vec[`LSCR_BIT_THR_FLAG] = thr_set;
		set_vec[`LSCR_BIT_CAL_FLAG] = cal_done;
		clr_vec    = read_clear ? 8'hff : (status_wr ? reg_wdata : 8'h00);
		nxt_flag_status = set_vec | (flag_status_ff & ~clr_vec);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) flag_status_ff <= 8'h00;
		else flag_status_ff <= nxt_flag_status;
	end

	// read mux; unmapped addresses and write-only gaps read as zero
	always_comb begin
		unique case (reg_addr)
			`LSCR_ADDR_WAIT_CFG: nxt_rdata = wait_cfg_ff;
			`LSCR_ADDR_GAIN_CFG: nxt_rdata = gain_cfg_ff;
			`LSCR_ADDR_REVISION: nxt_rdata = {`LSCR_REV_RESERVED, SILICON_REVISION};
			`LSCR_ADDR_DEV_TYPE: nxt_rdata = {DEVICE_TYPE, 2'h0};
			`LSCR_ADDR_STATUS:   nxt_rdata = flag_status_ff;
			`LSCR_ADDR_VIS_LO:   nxt_rdata = vis_res_ff[7:0];
			`LSCR_ADDR_VIS_HI:   nxt_rdata = vis_res_ff[15:8];
			`LSCR_ADDR_IR_LO:    nxt_rdata = ir_res_ff[7:0];
			`LSCR_ADDR_IR_HI:    nxt_rdata = ir_res_ff[15:8];
			`LSCR_ADDR_PKG_CODE: nxt_rdata = {4'h0, PACKAGE_CODE};
			`LSCR_ADDR_MISC_CFG: nxt_rdata = misc_cfg_ff;
			default:             nxt_rdata = 8'h00;
		endcase
	end

	// read data is the pre-clear value, captured at the same edge as the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd;
			if (reg_rd) rdata_ff <= nxt_rdata;
		end
	end

	// all checks share the one clock; reset masks them while it is high
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_status_read_clear;
		reg_rd && (reg_addr == `LSCR_ADDR_STATUS) && misc_cfg_ff[`LSCR_BIT_READ_CLEAR]
		&& !sat_event && !thr_set && !cal_done;
	endsequence

	a_flag_w1c: assert property (reg_wr && (reg_addr == `LSCR_ADDR_STATUS)
		&& reg_wdata[`LSCR_BIT_SAT_FLAG] && !sat_event |=> !flag_status_ff[`LSCR_BIT_SAT_FLAG])
		else $error("write of one did not clear saturation flag");

	a_flag_sticky: assert property (flag_status_ff[`LSCR_BIT_CAL_FLAG] && !reg_wr
		&& !reg_rd |=> flag_status_ff[`LSCR_BIT_CAL_FLAG])
		else $error("calibration flag fell without a clear");

	a_flag_w0_keeps: assert property (reg_wr && (reg_addr == `LSCR_ADDR_STATUS) && !reg_rd
		&& !reg_wdata[`LSCR_BIT_THR_FLAG] && flag_status_ff[`LSCR_BIT_THR_FLAG]
		|=> flag_status_ff[`LSCR_BIT_THR_FLAG])
		else $error("write of zero cleared threshold flag");

	a_read_clear: assert property (s_status_read_clear ##0 (flag_status_ff != 8'h00)
		|=> (flag_status_ff == 8'h00) && reg_rvalid && (reg_rdata == $past(flag_status_ff)))
		else $error("read-to-clear lost the value or left flags set");

	a_flag_events: assert property (sat_event && cal_done |=>
		flag_status_ff[`LSCR_BIT_SAT_FLAG] && flag_status_ff[`LSCR_BIT_CAL_FLAG])
		else $error("saturation or calibration event did not set its flag");

	// the result that brings the run up to the needed count raises the flag
	a_thr_persist: assert property (result_valid && thr_outside
		&& (persist_count_needed != 8'h00)
		&& (pers_cnt_ff == persist_count_needed - 8'h01)
		|=> flag_status_ff[`LSCR_BIT_THR_FLAG])
		else $error("threshold flag not set at persistence count");

	a_pers_inside: assert property (result_valid && !thr_outside |=>
		(pers_cnt_ff == 8'h00) && !$rose(flag_status_ff[`LSCR_BIT_THR_FLAG]))
		else $error("persistence counter not cleared inside window");

	a_id_reads: assert property (reg_rd && (reg_addr == `LSCR_ADDR_DEV_TYPE) |=>
		reg_rvalid && (reg_rdata == {DEVICE_TYPE, 2'h0}))
		else $error("device type read wrong");

	a_rev_reads: assert property (reg_rd && ((reg_addr == `LSCR_ADDR_REVISION)
		|| (reg_addr == `LSCR_ADDR_PKG_CODE)) |=> (reg_rdata[7:4] == 4'h0) ? 
		(reg_rdata == {4'h0, PACKAGE_CODE}) : (reg_rdata[2:0] == SILICON_REVISION))
		else $error("revision or package code read wrong");

	a_result_reset: assert property ($past(sys_rst) |-> (vis_res_ff == 16'h0000)
		&& (ir_res_ff == 16'h0000) && !misc_cfg_ff[`LSCR_BIT_READ_CLEAR])
		else $error("results or read-to-clear not zero after reset");

	a_gain_mult: assert property ($past(gain_cfg_ff[1:0]) == 2'b10 |-> gain_mult_ff == 7'h10)
		else $error("gain code two did not give sixteen");

	// each event alone sets its own flag; a broken set term cannot hide behind the other
	a_sat_sets: assert property (sat_event |=>
		flag_status_ff[`LSCR_BIT_SAT_FLAG])
		else $error("saturation event did not set its flag");

	a_cal_sets: assert property (cal_done |=>
		flag_status_ff[`LSCR_BIT_CAL_FLAG])
		else $error("calibration event did not set its flag");

	// reserved status bits have no set term, so nothing may ever raise them
	a_flag_reserved: assert property ((flag_status_ff & 8'h67) == 8'h00)
		else $error("reserved status bit set");

	// a status write with no read strobe in the same cycle
	sequence s_status_clear_write;
		reg_wr && (reg_addr == `LSCR_ADDR_STATUS) && !reg_rd;
	endsequence

	a_cal_w1c: assert property (s_status_clear_write ##0 reg_wdata[`LSCR_BIT_CAL_FLAG]
		##0 !cal_done |=> !flag_status_ff[`LSCR_BIT_CAL_FLAG])
		else $error("write of one did not clear calibration flag");

	// with read-to-clear off a status read must not drop any flag
	a_read_keeps: assert property (reg_rd && (reg_addr == `LSCR_ADDR_STATUS) && !reg_wr
		&& !misc_cfg_ff[`LSCR_BIT_READ_CLEAR] |=>
		((flag_status_ff & $past(flag_status_ff)) == $past(flag_status_ff)))
		else $error("status read cleared flags with read-to-clear off");

	// one valid cycle per read strobe; the data word holds between reads
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe gave no valid cycle");

	a_read_idle: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
		else $error("read data moved without a read strobe");

	// results move only with result_valid; register writes never reach them
	a_result_ro: assert property (!result_valid |=>
		$stable(vis_res_ff) && $stable(ir_res_ff))
		else $error("result register changed without a new result");

	// every gain code, not only one, maps to its factor a cycle later
	a_gain_code: assert property (!$past(sys_rst) |->
		gain_mult_ff == (7'h01 << {$past(gain_cfg_ff[1:0]), 1'b0}))
		else $error("gain factor does not match the gain code");

	// wait configuration writes land whole, reserved bits included; the misc check covers only its read-to-clear bit
	a_wait_write: assert property (reg_wr && (reg_addr == `LSCR_ADDR_WAIT_CFG)
		|=> (wait_cfg_ff == $past(reg_wdata))
		&& (wait_stretch_enable == $past(reg_wdata[`LSCR_BIT_WAIT_STRETCH])))
		else $error("wait configuration write did not land");

	a_misc_write: assert property (reg_wr && (reg_addr == `LSCR_ADDR_MISC_CFG)
		|=> misc_cfg_ff[`LSCR_BIT_READ_CLEAR] == $past(reg_wdata[`LSCR_BIT_READ_CLEAR]))
		else $error("read-to-clear control write did not land");

endmodule : lscr_regs

// >>> verification/lscr_host_model.sv
// host side of the register port: byte writes and reads launched at the falling edge
`timescale 1ns/1ps
`include "lscr_params.svh"
module lscr_host_model (
	input  wire logic                 clk,        // system clock
	output logic [7:0]                reg_addr,   // register address
	output logic                      reg_wr,     // write strobe
	output logic                      reg_rd,     // read strobe
	output lscr_pkg::lscr_byte_t      reg_wdata,  // write data
	input  wire lscr_pkg::lscr_byte_t reg_rdata,  // read data
	input  wire logic                 reg_rvalid  // read data valid
);
	import lscr_pkg::*;

	// idle bus at time zero
	initial begin
		reg_addr  = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_wdata = 8'h00;
	end

	// one strobe cycle; idle lines then show the inverse so stale values never match by luck
	task automatic wr(input logic [7:0] a, input lscr_byte_t v);
		@(negedge clk);
		reg_addr  = a;
		reg_wdata = v;
		reg_wr    = 1'b1;
		@(negedge clk);
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~v;
	endtask : wr

	// data is taken only when valid shows in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output lscr_byte_t v);
		@(negedge clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge clk);
		reg_rd   = 1'b0;
		reg_addr = ~a;
		v        = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask : rd

	// reserved fields always carry their fixed pattern
	task automatic wr_wait(input logic s);
		wr(`LSCR_ADDR_WAIT_CFG, {5'b10000, s, 2'b00});
	endtask : wr_wait
endmodule : lscr_host_model

// >>> verification/lscr_regs_tb.sv
// self-checking bench for the light sensor register bank
`timescale 1ns/1ps
`include "lscr_params.svh"
`define LSCR_CHK(a, e) begin \
	checked++; \
	if ((a) !== (e)) begin \
		failures++; \
		$display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
	end \
end
module lscr_regs_tb;
	import lscr_pkg::*;

	localparam logic [2:0] SREV  = 3'h5;  // arbitrary value
	localparam logic [5:0] DTYPE = 6'h15; // arbitrary value
	localparam logic [3:0] PKG   = 4'h9;  // arbitrary value
	localparam int         STEP  = 3;     // short wait step keeps the run brief

	logic        clk, sys_rst, reg_wr, reg_rd, reg_rvalid;
	logic [7:0]  reg_addr, persist_count_needed, wait_period_value;
	lscr_byte_t  reg_wdata, reg_rdata;
	logic        sat_event, cal_done, result_valid, thr_outside;
	logic        wait_start, wait_done, wait_stretch_enable;
	logic [15:0] vis_result, ir_result;
	lscr_gain_t  gain_select;
	logic [6:0]  gain_mult;
	int          failures, checked, cycles, n;
	logic [7:0]  ra [12] = '{`LSCR_ADDR_WAIT_CFG, `LSCR_ADDR_GAIN_CFG, `LSCR_ADDR_MISC_CFG,
		`LSCR_ADDR_REVISION, `LSCR_ADDR_DEV_TYPE, `LSCR_ADDR_STATUS, `LSCR_ADDR_VIS_LO,
		`LSCR_ADDR_VIS_HI, `LSCR_ADDR_IR_LO, `LSCR_ADDR_IR_HI, `LSCR_ADDR_PKG_CODE, 8'h50};
	lscr_byte_t  rv [12] = '{`LSCR_RST_WAIT_CFG, `LSCR_RST_GAIN_CFG, `LSCR_RST_MISC_CFG,
		{`LSCR_REV_RESERVED, SREV}, {DTYPE, 2'b00}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		{4'h0, PKG}, 8'h00};

	lscr_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	lscr_regs #(.SILICON_REVISION(SREV), .DEVICE_TYPE(DTYPE), .PACKAGE_CODE(PKG),
		.WAIT_STEP_CYCLES(STEP)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .sat_event(sat_event), .cal_done(cal_done),
		.result_valid(result_valid), .vis_result(vis_result), .ir_result(ir_result),
		.thr_outside(thr_outside), .persist_count_needed(persist_count_needed),
		.wait_start(wait_start), .wait_period_value(wait_period_value),
		.wait_done(wait_done), .wait_stretch_enable(wait_stretch_enable),
		.gain_select(gain_select), .gain_mult(gain_mult));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic chk_rd(input logic [7:0] a, input lscr_byte_t e);
		lscr_byte_t v;
		host.rd(a, v);
		`LSCR_CHK(v, e)
	endtask : chk_rd

	// one-cycle event pulses from the front end
	task automatic ev(input logic s, input logic c, input logic r, input logic o);
		@(negedge clk);
		sat_event    = s;
		cal_done     = c;
		result_valid = r;
		thr_outside  = o;
		@(negedge clk);
		sat_event    = 1'b0;
		cal_done     = 1'b0;
		result_valid = 1'b0;
	endtask : ev

	// launch a wait and count edges from launch to the done pulse
	task automatic tw(input logic s, input logic [7:0] p, input int e);
		host.wr_wait(s);
		`LSCR_CHK(wait_stretch_enable, s)
		@(negedge clk);
		wait_start        = 1'b1;
		wait_period_value = p;
		@(negedge clk);
		wait_start = 1'b0;
		n = 0;
		while (wait_done !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		`LSCR_CHK(n, e)
	endtask : tw

	initial begin
		sys_rst = 1'b1;
		{sat_event, cal_done, result_valid, thr_outside, wait_start} = 5'h00;
		{vis_result, ir_result} = 32'h0000_0000;
		persist_count_needed = 8'h00;
		wait_period_value = 8'h00;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		// reset values, then writes to read-only and unmapped places change nothing
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 12; i++) begin
				chk_rd(ra[i], rv[i]);
			end
			for (int i = 3; i < 12; i++) begin
				host.wr(ra[i], 8'hff);
			end
		end
		// every gain code; the factor lags the register by a cycle
		for (int g = 0; g < 4; g++) begin
			host.wr(`LSCR_ADDR_GAIN_CFG, 8'(g));
			@(negedge clk);
			`LSCR_CHK(gain_select, lscr_gain_t'(g))
			`LSCR_CHK(gain_mult, 7'(1 << (2 * g)))
		end
		// flags hold until a one is written; zero writes leave them
		ev(1'b1, 1'b1, 1'b0, 1'b0);
		repeat (5) @(negedge clk);
		chk_rd(`LSCR_ADDR_STATUS, 8'h88);
		host.wr(`LSCR_ADDR_STATUS, 8'h08);
		chk_rd(`LSCR_ADDR_STATUS, 8'h80);
		host.wr(`LSCR_ADDR_STATUS, 8'h00);
		chk_rd(`LSCR_ADDR_STATUS, 8'h80);
		host.wr(`LSCR_ADDR_STATUS, 8'h80);
		chk_rd(`LSCR_ADDR_STATUS, 8'h00);
		// an inside result restarts the run of three
		persist_count_needed = 8'h03;
		vis_result = 16'h1234;
		ir_result  = 16'habcd;
		for (int i = 0; i < 5; i++) begin
			ev(1'b0, 1'b0, 1'b1, i != 2);
		end
		chk_rd(`LSCR_ADDR_STATUS, 8'h00);
		ev(1'b0, 1'b0, 1'b1, 1'b1);
		chk_rd(`LSCR_ADDR_STATUS, 8'h10);
		host.wr(`LSCR_ADDR_STATUS, 8'h08);
		chk_rd(`LSCR_ADDR_STATUS, 8'h10);
		chk_rd(`LSCR_ADDR_VIS_LO, 8'h34);
		chk_rd(`LSCR_ADDR_VIS_HI, 8'h12);
		chk_rd(`LSCR_ADDR_IR_LO, 8'hcd);
		chk_rd(`LSCR_ADDR_IR_HI, 8'hab);
		host.wr(`LSCR_ADDR_STATUS, 8'h10);
		// read-to-clear returns the flags once, then zero
		host.wr(`LSCR_ADDR_MISC_CFG, 8'hcc);
		ev(1'b1, 1'b0, 1'b0, 1'b0);
		chk_rd(`LSCR_ADDR_STATUS, 8'h80);
		chk_rd(`LSCR_ADDR_STATUS, 8'h00);
		host.wr(`LSCR_ADDR_MISC_CFG, `LSCR_RST_MISC_CFG);
		// wait lengths, plain and stretched; done shows (value + 1) steps after launch
		tw(1'b0, 8'h00, STEP);
		tw(1'b0, 8'h04, 5 * STEP);
		tw(1'b1, 8'h01, 2 * STEP * `LSCR_WAIT_STRETCH_FACTOR);
		chk_rd(`LSCR_ADDR_WAIT_CFG, 8'h84);
		finish_test();
	end
endmodule : lscr_regs_tb
